/* hw/scfc_setup_ctrl.sv */
// Second setup register: read timing, clock multiplier, core halt/restart, features
`timescale 1ns/1ps
module scfc_setup_ctrl
  import scfc_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Host register access, already decoded for this register
  input  wire logic        setup_wr,
  input  wire logic        setup_rd,
  input  wire logic [7:0]  wr_data,
  output logic [7:0]       rd_data,
  // Command register write strobe and data
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_data,
  // Host bus cycle qualifiers
  input  wire logic        bus_muxed,
  input  wire logic        host_read_cycle,
  // RAM init and line state from the core
  input  wire logic        ram_init_req,
  input  wire logic        line_idle,
  // Outputs to the core and clock logic
  output logic             fast_read_active,
  output logic             pll_power_on,
  output logic             clk_sel_40mhz,
  output logic             pll_locked,
  output logic             core_halted,
  output logic             enhanced_en,
  output logic             sync_cmd_en,
  output logic             ram_init_go
);
  import scfc_pkg::*;

  logic [7:0]  setup_ff;
  logic [7:0]  nxt_setup;
  logic [7:0]  rd_ff;
  logic [7:0]  nxt_rd;
  scfc_state_t state_ff;
  scfc_state_t nxt_state;
  logic        pwr_ff;
  logic        nxt_pwr;
  logic        fr_ff;
  logic        nxt_fr;
  logic        c40_ff;
  logic        nxt_c40;
  logic        halt_ff;
  logic        nxt_halt;
  logic        efe_ff;
  logic        nxt_efe;
  logic        sync_ff;
  logic        nxt_sync;
  logic        rig_ff;
  logic        nxt_rig;
  logic        lck_ff;
  logic        nxt_lck;
  logic        cms_change;
  logic        lock_done;

  // Any write carrying a different multiplier code counts as a change.
  // A host keeping the once-only limit sees exactly one lock period;
  // a second change simply restarts the lock wait and the halt.
  assign cms_change = setup_wr && (wr_data[CMS_HI:CMS_LO] != setup_ff[CMS_HI:CMS_LO]);

  scfc_lock_timer u_lock (
    .ref_clk (ref_clk),
    .reset   (reset),
    .start   (cms_change),
    .locked  (lock_done)
  );

  // Register group: host writes and readback
  always_comb begin
    nxt_setup = setup_ff;
    nxt_rd    = rd_ff;
    if (setup_wr) begin
      nxt_setup = wr_data;
      nxt_setup[RSV_BIT] = 1'b0;
    end
    if (setup_rd) begin
      // Read in the same cycle as a write returns the old value
      nxt_rd          = setup_ff;
      nxt_rd[RSV_BIT] = 1'b0;
    end
  end

  // Halt and power group
  always_comb begin
    nxt_state = state_ff;
    nxt_pwr   = pwr_ff;
    case (state_ff)
      SCFC_RUN: begin
        if (cms_change) begin
          nxt_state = SCFC_LOCK;
          nxt_pwr   = 1'b1;
        end
      end
      SCFC_LOCK: begin
        // Restart before lock is ignored; host is expected to wait 1 ms anyway
        if (lock_done) begin
          nxt_state = SCFC_HALTED;
        end
      end
      SCFC_HALTED: begin
        if (cmd_wr && cmd_data == CMD_RESTART) begin
          nxt_state = SCFC_RUN;
        end
      end
      default: nxt_state = SCFC_RUN;
    endcase
    // A change in any state restarts the lock wait
    if (cms_change) begin
      nxt_state = SCFC_LOCK;
    end
  end

  // Output group: every port below leaves from its own flop
  always_comb begin
    // Fast timing only on reads of a non-multiplexed bus; writes never see it
    nxt_fr = 1'b0;
    if (setup_ff[FRT_BIT] && !bus_muxed && host_read_cycle) begin
      nxt_fr = 1'b1;
    end
    // Reserved codes leave the core on 20 MHz even with the PLL awake
    nxt_c40 = 1'b0;
    if (pwr_ff && lock_done && (setup_ff[CMS_HI:CMS_LO] == CMS_40MHZ)) begin
      nxt_c40 = 1'b1;
    end
    // Halt follows the next state so the core stops right after the write
    nxt_halt = (nxt_state != SCFC_RUN);
    // Enhanced is a plain copy, sync the inverted skip bit; enhanced 0 keeps the legacy behaviour
    nxt_efe  = setup_ff[EFE_BIT];
    nxt_sync = !setup_ff[SLIS_BIT];
    // Init writes wait for an idle line unless the skip bit is set,
    // and only while state_ff is SCFC_RUN, so one can still go out in the first halted cycle of a clock change
    nxt_rig = 1'b0;
    if (ram_init_req && (state_ff == SCFC_RUN)) begin
      nxt_rig = setup_ff[SLIS_BIT] || line_idle;
    end
    // Lock is only reported while the PLL is powered
    nxt_lck = pwr_ff && lock_done;
  end

  // Register group flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      setup_ff <= SETUP_RESET;
      rd_ff    <= SETUP_RESET;
    end else begin
      setup_ff <= nxt_setup;
      rd_ff    <= nxt_rd;
    end
  end

  // Halt and power flops; power is sticky until a hardware reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= SCFC_RUN;
      pwr_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pwr_ff   <= nxt_pwr;
    end
  end

  // Output flops; sync command enabled by default
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fr_ff   <= 1'b0;
      c40_ff  <= 1'b0;
      halt_ff <= 1'b0;
      efe_ff  <= 1'b0;
      sync_ff <= 1'b1;
      rig_ff  <= 1'b0;
      lck_ff  <= 1'b0;
    end else begin
      fr_ff   <= nxt_fr;
      c40_ff  <= nxt_c40;
      halt_ff <= nxt_halt;
      efe_ff  <= nxt_efe;
      sync_ff <= nxt_sync;
      rig_ff  <= nxt_rig;
      lck_ff  <= nxt_lck;
    end
  end

  // Port map of the output flops
  assign rd_data          = rd_ff;
  assign fast_read_active = fr_ff;
  assign pll_power_on     = pwr_ff;
  assign clk_sel_40mhz    = c40_ff;
  assign pll_locked       = lck_ff;
  assign core_halted      = halt_ff;
  assign enhanced_en      = efe_ff;
  assign sync_cmd_en      = sync_ff;
  assign ram_init_go      = rig_ff;
endmodule

/* hw/scfc_pkg.sv */
// Constants shared by the clock and feature setup block
package scfc_pkg;
  // Register field positions
  localparam int unsigned FRT_BIT     = 7;
  localparam int unsigned RSV_BIT     = 6;
  localparam int unsigned CMS_HI      = 5;
  localparam int unsigned CMS_LO      = 4;
  localparam int unsigned EFE_BIT     = 3;
  localparam int unsigned SLIS_BIT    = 2;
  // Reset value and multiplier codes
  localparam logic [7:0]  SETUP_RESET = 8'h00;
  localparam logic [1:0]  CMS_20MHZ   = 2'h0;
  localparam logic [1:0]  CMS_40MHZ   = 2'h1;
  localparam logic [1:0]  CMS_RSVD    = 2'h2;
  // Command that restarts the core
  localparam logic [7:0]  CMD_RESTART = 8'h18;
  // PLL lock time, typical, in ns
  localparam int unsigned PLL_LOCK_NS = 8000;
  localparam int unsigned CLK_PER_NS  = 10;
  localparam int unsigned PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  localparam int unsigned LOCK_CNT_W  = 10;

  typedef enum logic [1:0] {
    SCFC_RUN    = 2'b00,
    SCFC_LOCK   = 2'b01,
    SCFC_HALTED = 2'b10
  } scfc_state_t;
endpackage

/* hw/scfc_lock_timer.sv */
// Down counter that models PLL lock time after wake
`timescale 1ns/1ps
module scfc_lock_timer
  import scfc_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Control
  input  wire logic                  start,
  // Status
  output logic                       locked
);
  logic [LOCK_CNT_W-1:0] cnt_ff;
  logic [LOCK_CNT_W-1:0] nxt_cnt;
  logic                  locked_ff;
  logic                  nxt_locked;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_locked = locked_ff;
    if (start) begin
      nxt_cnt    = LOCK_CNT_W'(PLL_LOCK_CYC - 1);
      nxt_locked = 1'b0;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_locked = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_ff    <= '0;
      locked_ff <= 1'b0;
    end else begin
      cnt_ff    <= nxt_cnt;
      locked_ff <= nxt_locked;
    end
  end

  assign locked = locked_ff;
endmodule

/* verification/scfc_chk_assertions.sv */
// Checker for the clock and feature setup block
`timescale 1ns/1ps
module scfc_chk
  import scfc_pkg::*;
(
  // Clock, reset and strobes
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       setup_wr,
  input wire logic       setup_rd,
  input wire logic       cmd_wr,
  input wire logic       bus_muxed,
  input wire logic       host_read_cycle,
  // Levels
  input wire logic       ram_init_req,
  input wire logic       line_idle,
  input wire logic       pll_power_on,
  input wire logic       clk_sel_40mhz,
  input wire logic       pll_locked,
  input wire logic       core_halted,
  input wire logic       enhanced_en,
  input wire logic       sync_cmd_en,
  input wire logic       ram_init_go,
  input wire logic       fast_read_active,
  // Data
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] cmd_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_chg; setup_wr && wr_data[5:4] != 2'h0 && !pll_power_on; endsequence
  sequence s_up; pll_power_on && core_halted; endsequence
  property p_fast; fast_read_active |-> $past(host_read_cycle && !bus_muxed); endproperty
  a_fast: assert property (p_fast) else $error("fast read");
  property p_feat; setup_wr |-> ##2 enhanced_en == $past(wr_data[3], 2) && sync_cmd_en != $past(wr_data[2], 2);
  endproperty
  a_feat: assert property (p_feat) else $error("features");
  property p_rsv; setup_rd |=> !rd_data[RSV_BIT]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit");
  property p_pwr; $rose(pll_power_on) |-> $past(setup_wr) || $past(setup_wr, 2); endproperty
  a_pwr: assert property (p_pwr) else $error("pll power");
  property p_halt; s_chg |-> ##2 s_up; endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_hold; core_halted && !(cmd_wr && cmd_data == CMD_RESTART) |=> core_halted; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_go; $fell(core_halted) |-> $past(cmd_wr) && $past(cmd_data) == CMD_RESTART; endproperty
  a_go: assert property (p_go) else $error("restart");
  property p_clk; clk_sel_40mhz |-> pll_locked && pll_power_on; endproperty
  a_clk: assert property (p_clk) else $error("clock select");
  property p_idle; ram_init_go && sync_cmd_en |-> $past(ram_init_req && line_idle); endproperty
  a_idle: assert property (p_idle) else $error("ram init");
endmodule
bind scfc_setup_ctrl scfc_chk u_chk (.*);

/* verification/scfc_host.sv */
// Host model driving the register strobes
`timescale 1ns/1ps
module scfc_host (
  // Clock
  input  wire logic ref_clk,
  // Strobes and data
  output logic      setup_wr = 0, setup_rd = 0, cmd_wr = 0,
  output logic [7:0] wr_data = 0, cmd_data = 0
);
  // Released data inverted so stale values never look valid
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk) #1;
    setup_wr = 1;
    wr_data = d;
    @(posedge ref_clk) #1;
    setup_wr = 0;
    wr_data = ~d;
  endtask
  task automatic rd;
    @(posedge ref_clk) #1;
    setup_rd = 1;
    @(posedge ref_clk) #1;
    setup_rd = 0;
  endtask
  task automatic cmd(input logic [7:0] d);
    @(posedge ref_clk) #1;
    cmd_wr = 1;
    cmd_data = d;
    @(posedge ref_clk) #1;
    cmd_wr = 0;
    cmd_data = ~d;
  endtask
endmodule

/* verification/setup_two_clock_feature_ctrl_test.sv */
// Self-checking bench for the clock and feature setup block
`timescale 1ns/1ps
module setup_two_clock_feature_ctrl_test;
  import scfc_pkg::*;
  logic       ref_clk = 0, reset = 1, bus_muxed = 0, host_read_cycle = 0, ram_init_req = 0, line_idle = 0;
  logic       setup_wr, setup_rd, cmd_wr, fast_read_active, pll_power_on, clk_sel_40mhz;
  logic       pll_locked, core_halted, enhanced_en, sync_cmd_en, ram_init_go;
  logic [7:0] wr_data, cmd_data, rd_data;
  int         err_total = 0, compares = 0, seed = 32'h2cb3, m;
  wire [7:0]  sts = {fast_read_active, pll_power_on, clk_sel_40mhz, pll_locked, core_halted,
                     enhanced_en, sync_cmd_en, ram_init_go};
  initial forever #5 ref_clk = ~ref_clk;
  scfc_host u_host (.*);
  scfc_setup_ctrl u_dut (.*);
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cy(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50_000;
    err_total++;
    stop_test();
  end
  initial begin
    cy(20);
    reset = 0;
    chk("reset", {rd_data[6:0], sts[0]}, 8'h00);
    chk("status", sts, 8'h02);
    // Multiplier kept at default, it may change only once
    for (int i = 0; i < 8; i++) begin
      m = $random(seed) & 32'h0000_00cf;
      u_host.wr(m[7:0]);
      u_host.rd();
      cy(1);
      chk("rd_data", rd_data, m[7:0] & 8'hbf);
      chk("fields", sts, {5'h00, m[3], !m[2], 1'b0});
    end
    $display("register test done");
    for (int b = 0; b < 8; b++) begin
      u_host.wr({b[2], 7'h00});
      {bus_muxed, host_read_cycle} = b[1:0];
      cy(2);
      chk("fast", fast_read_active, b == 5);
    end
    $display("read timing test done");
    for (int c = 0; c < 8; c++) begin
      u_host.wr({5'h00, c[2], 2'h0});
      {ram_init_req, line_idle} = c[1:0];
      cy(2);
      chk("init", {ram_init_go, sync_cmd_en}, {c[1] && (c[2] || c[0]), !c[2]});
    end
    $display("ram init test done");
    // New design: 40 MHz with enhanced functions on
    u_host.wr(8'h18);
    cy(2);
    chk("halt", sts, 8'h4e);
    u_host.cmd(CMD_RESTART);
    cy(2);
    chk("early", core_halted, 1);
    // Lock wait shortened from the host's 1 ms
    cy(PLL_LOCK_CYC);
    chk("lock", sts, 8'h7e);
    u_host.cmd(8'h17);
    cy(2);
    chk("other cmd", core_halted, 1);
    u_host.cmd(CMD_RESTART);
    cy(2);
    chk("run", sts, 8'h77);
    $display("multiplier test done");
    // Mid-run hardware reset puts the PLL back to sleep
    reset = 1;
    cy(2);
    reset = 0;
    ram_init_req = 0;
    chk("re-reset", sts, 8'h02);
    chk("re-reset rd", rd_data, 8'h00);
    // Reserved multiplier code keeps the 20 MHz clock
    u_host.wr(8'h20);
    cy(2);
    chk("rsvd halt", sts, 8'h4a);
    cy(PLL_LOCK_CYC);
    chk("rsvd lock", sts, 8'h5a);
    u_host.cmd(CMD_RESTART);
    cy(2);
    chk("rsvd run", sts, 8'h52);
    $display("reserved code test done");
    stop_test();
  end
endmodule
